// ---- logic/ebcrdy_pkg.sv ----
// Package: constants and types for the external bus cycle sequencer
// =====================================================================
package ebcrdy_pkg;

  // =====================================================================
  // Phase encodings and limits
  localparam int PH_AB_MAX = 5;
  localparam int PH_C_MAX = 3;
  localparam int PH_D_MAX = 1;
  localparam int PH_E_MAX = 32;
  localparam int PH_F_MAX = 3;
  localparam int CNT_W = 6;
  localparam int NUM_CS = 4;
  localparam int CS_W = 2;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  // Per-region timing word field positions
  localparam int F_AB_LO = 0;   // 3 bits: address setup phase length
  localparam int F_C_LO = 3;    // 2 bits: command delay phase
  localparam int F_D_LO = 5;    // 1 bit: write data lead phase
  localparam int F_E_LO = 6;    // 5 bits: access phase length minus one
  localparam int F_F_LO = 11;   // 2 bits: recovery phase
  localparam int F_RDYEN = 13;  // Handshake enable
  localparam int F_RDYPOL = 14; // 1: ready is high
  localparam int F_ASYNC = 15;  // Asynchronous handshake
  localparam int F_MUX = 16;    // Multiplexed bus
  localparam int TIMING_W = 17;
  // Minimum spacing of bus transitions
  localparam real MIN_TRANS_NS = 12.5;
  localparam real CLK_PERIOD_NS = 100.0;
  localparam int MIN_TRANS_CYC = (MIN_TRANS_NS / CLK_PERIOD_NS) > 1.0 ? 2 : 1;
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_AB = 7'h02,
    ST_C = 7'h04,
    ST_D = 7'h08,
    ST_E = 7'h10,
    ST_RDY = 7'h20,
    ST_F = 7'h40
  } ebcrdy_state_t;

endpackage

// ---- logic/ebcrdy_ready_sync.sv ----
// Ready input front end: pin synchroniser and polarity/mode selection
`timescale 1ns/1ps
module ebcrdy_ready_sync (
  input wire logic ref_clk,   // System clock
  input wire logic rst_b,     // Synchronous reset, active low
  input wire logic readyPin,  // Raw ready pin
  input wire logic polHigh,   // 1: high means ready
  input wire logic asyncMode, // 1: asynchronous handshake
  output logic readyOk        // Qualified ready level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  wire logic syncLvl;
  wire logic asyncLvl;

  // =====================================================================
  // Two stages for every pin; async adds a third stage, one waitstate
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= readyPin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Polarity applied after the flops, first flop stays private
  assign syncLvl = s2_r ~^ polHigh;
  assign asyncLvl = s3_r ~^ polHigh;
  assign readyOk = asyncMode ? asyncLvl : syncLvl;
endmodule // ebcrdy_ready_sync

// ---- logic/ebcrdy_seq.sv ----
// External bus cycle sequencer with ready handshake
`timescale 1ns/1ps
module ebcrdy_seq
  import ebcrdy_pkg::*;
#(
  parameter int NCS = NUM_CS
) (
  input wire logic ref_clk,                        // System clock, 10 MHz
  input wire logic rst_b,                          // Synchronous reset, active low
  input wire logic reqValid,                       // Access request
  input wire logic reqWrite,                       // 1: write
  input wire logic [CS_W-1:0] reqCs,               // Decoded region
  input wire logic [ADDR_W-1:0] reqAddr,           // Access address
  input wire logic [DATA_W-1:0] reqWdata,          // Write data
  input wire logic [NCS*TIMING_W-1:0] csTiming,    // Per-region timing words
  input wire logic readyPin,                       // Ready handshake pin
  input wire logic [DATA_W-1:0] dataIn,            // Read data pins (demux)
  input wire logic [DATA_W-1:0] adIn,              // Shared lines input (mux)
  output logic reqReady_r,                         // Request taken
  output logic done_r,                             // Cycle end pulse
  output logic [DATA_W-1:0] rdata_r,               // Captured read data
  output logic [ADDR_W-1:0] addrOut_r,             // Address lines
  output logic [DATA_W-1:0] dataOut_r,             // Demux write data
  output logic dataOe_r,                           // Demux data enable
  output logic [DATA_W-1:0] adOut_r,               // Shared lines output
  output logic adOe_r,                             // Shared lines enable
  output logic aleOut_r,                           // Address latch enable
  output logic rdN_r,                              // Read strobe, active low
  output logic wrN_r,                              // Write strobe, active low
  output logic [NCS-1:0] csN_r,                    // Chip selects, active low
  output logic busRefClkOut                        // Reference clock output
);

  // =====================================================================
  // Field extraction of a timing word
  function automatic logic [CNT_W-1:0] fld(input logic [TIMING_W-1:0] w, input int lo,
                                           input int wd);
    logic [CNT_W-1:0] v;
    v = '0;
    for (int i = 0; i < wd; i++) v[i] = w[lo+i];
    return v;
  endfunction

  ebcrdy_state_t state_r;
  ebcrdy_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [TIMING_W-1:0] tim_r;
  logic write_r;
  logic [CS_W-1:0] cs_r;
  logic [DATA_W-1:0] wdata_r;
  logic [ADDR_W-1:0] addrHold_r;
  logic [DATA_W-1:0] dIn1_r;
  logic [DATA_W-1:0] dIn2_r;
  logic [DATA_W-1:0] ad1_r;
  logic [DATA_W-1:0] ad2_r;
  logic rdyStrobe_r;
  wire logic readyOk;
  wire logic [TIMING_W-1:0] reqTim;
  wire logic [CNT_W-1:0] lenAB;
  wire logic [CNT_W-1:0] lenC;
  wire logic [CNT_W-1:0] lenD;
  wire logic [CNT_W-1:0] lenE;
  wire logic [CNT_W-1:0] lenF;
  wire logic rdyEn;
  wire logic muxMode;
  wire logic lastCnt;
  wire logic readEnd;

  // =====================================================================
  // Decode of the selected region timing
  assign reqTim = csTiming[reqCs*TIMING_W +: TIMING_W];
  assign lenAB = fld(tim_r, F_AB_LO, 3);
  assign lenC = fld(tim_r, F_C_LO, 2);
  assign lenD = fld(tim_r, F_D_LO, 1);
  assign lenE = fld(tim_r, F_E_LO, 5) + CNT_W'(1);
  assign lenF = fld(tim_r, F_F_LO, 2);
  assign rdyEn = tim_r[F_RDYEN];
  assign muxMode = tim_r[F_MUX];
  assign lastCnt = (cnt_r == CNT_W'(1));
  // Ready only counts in the handshake wait state, after mandatory waitstates
  assign readEnd = !write_r && ((state_r == ST_E && lastCnt && !rdyEn)
                   || (state_r == ST_RDY && readyOk));

  ebcrdy_ready_sync u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .readyPin(readyPin),
    .polHigh(tim_r[F_RDYPOL]),
    .asyncMode(tim_r[F_ASYNC]),
    .readyOk(readyOk)
  );

  // Reference clock is the system clock itself
  assign busRefClkOut = ref_clk;

  // =====================================================================
  // Phase sequencing; zero-length C, D and F phases are skipped, a zero AB length still takes one cycle
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (reqValid && reqReady_r) begin
          state_nxt = ST_AB;
          cnt_nxt = fld(reqTim, F_AB_LO, 3);
          if (cnt_nxt == '0) cnt_nxt = CNT_W'(1);
        end
      end
      ST_AB: begin
        if (lastCnt) begin
          if (lenC != '0) begin
            state_nxt = ST_C;
            cnt_nxt = lenC;
          end else if (lenD != '0) begin
            state_nxt = ST_D;
            cnt_nxt = lenD;
          end else begin
            state_nxt = ST_E;
            cnt_nxt = lenE;
          end
        end else cnt_nxt = cnt_r - CNT_W'(1);
      end
      ST_C: begin
        if (lastCnt) begin
          if (lenD != '0) begin
            state_nxt = ST_D;
            cnt_nxt = lenD;
          end else begin
            state_nxt = ST_E;
            cnt_nxt = lenE;
          end
        end else cnt_nxt = cnt_r - CNT_W'(1);
      end
      ST_D: begin
        state_nxt = ST_E;
        cnt_nxt = lenE;
      end
      ST_E: begin
        if (lastCnt) begin
          if (rdyEn) state_nxt = ST_RDY;
          else if (lenF != '0) begin
            state_nxt = ST_F;
            cnt_nxt = lenF;
          end else state_nxt = ST_IDLE;
        end else cnt_nxt = cnt_r - CNT_W'(1);
      end
      ST_RDY: begin
        if (readyOk) begin
          if (lenF != '0) begin
            state_nxt = ST_F;
            cnt_nxt = lenF;
          end else state_nxt = ST_IDLE;
        end
      end
      ST_F: begin
        if (lastCnt) state_nxt = ST_IDLE;
        else cnt_nxt = cnt_r - CNT_W'(1);
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  wire logic cmdEnd = (state_r == ST_E && lastCnt && !rdyEn) || (state_r == ST_RDY && readyOk);
  wire logic toIdle = (state_nxt == ST_IDLE) && (state_r != ST_IDLE);
  wire logic start = (state_r == ST_IDLE) && reqValid && reqReady_r;
  wire logic cmdOn = (state_nxt == ST_E || state_nxt == ST_RDY);

  // =====================================================================
  // State, counter and latched request
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      tim_r <= '0;
      write_r <= 1'b0;
      cs_r <= '0;
      wdata_r <= DATA_RST;
      addrHold_r <= ADDR_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (start) begin
        tim_r <= reqTim;
        write_r <= reqWrite;
        cs_r <= reqCs;
        wdata_r <= reqWdata;
        addrHold_r <= reqAddr;
      end
    end
  end

  // Read input pins pass two flops before any use
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dIn1_r <= DATA_RST;
      dIn2_r <= DATA_RST;
      ad1_r <= DATA_RST;
      ad2_r <= DATA_RST;
    end else begin
      dIn1_r <= dataIn;
      dIn2_r <= dIn1_r;
      ad1_r <= adIn;
      ad2_r <= ad1_r;
    end
  end

  // =====================================================================
  // Bus outputs; strobes and read capture share one edge
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reqReady_r <= 1'b1;
      done_r <= 1'b0;
      rdata_r <= DATA_RST;
      addrOut_r <= ADDR_RST;
      dataOut_r <= DATA_RST;
      dataOe_r <= 1'b0;
      adOut_r <= DATA_RST;
      adOe_r <= 1'b0;
      aleOut_r <= 1'b0;
      rdN_r <= 1'b1;
      wrN_r <= 1'b1;
      csN_r <= '1;
      rdyStrobe_r <= 1'b0;
    end else begin
      reqReady_r <= (state_nxt == ST_IDLE) && !start;
      done_r <= toIdle;
      rdyStrobe_r <= cmdEnd;
      // Capture uses the two-flop delayed copy so an early address move cannot hurt
      if (readEnd) rdata_r <= muxMode ? ad2_r : dIn2_r;
      if (start) begin
        addrOut_r <= reqAddr;
        csN_r <= ~(NCS'(1) << reqCs);
        aleOut_r <= reqTim[F_MUX];
        adOut_r <= reqAddr[DATA_W-1:0];
        adOe_r <= reqTim[F_MUX];
      end else if (state_r == ST_AB && lastCnt) begin
        aleOut_r <= 1'b0;
        // Mux read releases lines; write puts data on them
        adOut_r <= wdata_r;
        adOe_r <= muxMode && write_r;
        dataOut_r <= wdata_r;
        dataOe_r <= !muxMode && write_r;
      end else if (toIdle) begin
        csN_r <= '1;
        adOe_r <= 1'b0;
        dataOe_r <= 1'b0;
      end
      // Strobes are flops, so their edges always sit a full clock apart
      rdN_r <= !(cmdOn && !write_r) || (state_r == ST_IDLE && !start) || cmdEnd;
      wrN_r <= !(cmdOn && write_r) || (state_r == ST_IDLE && !start) || cmdEnd;
    end
  end

  // =====================================================================
  // Checks
  a_phase_order: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ST_IDLE && state_nxt != ST_IDLE |=> state_r == ST_AB)
    else $error("cycle did not start with address phase");
  a_ready_ends: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ST_RDY && readyOk |=> state_r != ST_RDY)
    else $error("ready active did not end wait");
  a_ready_waits: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ST_RDY && !readyOk |=> state_r == ST_RDY)
    else $error("ready inactive did not insert waitstate");
  a_fixed_access: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ST_E && lastCnt && !rdyEn |=> state_r != ST_E && state_r != ST_RDY)
    else $error("access phase overran without handshake");
  a_no_early_rdy: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ST_E && !lastCnt |=> state_r == ST_E)
    else $error("ready considered before access waitstates");
  a_read_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
    readEnd |=> rdata_r == (muxMode ? $past(ad2_r) : $past(dIn2_r)))
    else $error("read data not captured at strobe end");
  a_strobe_rise: assert property (@(posedge ref_clk) disable iff (!rst_b)
    readEnd |=> rdN_r)
    else $error("read strobe not raised with capture");
  a_timing_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r != ST_IDLE && !start |=> $stable(tim_r))
    else $error("timing set changed mid cycle");
  a_idle_cs: assert property (@(posedge ref_clk) disable iff (!rst_b)
    done_r |-> csN_r == '1)
    else $error("chip select active after cycle end");
  // Latched copies must match what stands on the pins for the whole cycle
  a_cs_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r != ST_IDLE |-> csN_r == NCS'(~(NCS'(1) << cs_r)))
    else $error("chip select differs from latched region");
  a_addr_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r != ST_IDLE |-> addrOut_r == addrHold_r)
    else $error("address moved during cycle");
  a_strobe_end: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rdyStrobe_r |-> rdN_r && wrN_r)
    else $error("strobe still low after cycle end");
  a_access_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ST_E |-> cnt_r >= CNT_W'(1) && cnt_r <= CNT_W'(PH_E_MAX))
    else $error("access phase count out of range");
  c_read: cover property (@(posedge ref_clk) disable iff (!rst_b) readEnd);
  c_write: cover property (@(posedge ref_clk) disable iff (!rst_b)
    cmdEnd && write_r);
  c_wait: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ST_RDY && !readyOk);
  c_async: cover property (@(posedge ref_clk) disable iff (!rst_b)
    state_r == ST_RDY && tim_r[F_ASYNC] && readyOk);

endmodule // ebcrdy_seq

// ---- verif/ebcrdy_partner.sv ----
// Behavioural external memory with a ready handshake, far side of the bus
`timescale 1ns/1ps
module ebcrdy_partner (
  input wire logic clk,            // Bus reference clock
  input wire logic [3:0] csN,      // Chip selects, active low
  input wire logic rdN,            // Read strobe, active low
  input wire logic wrN,            // Write strobe, active low
  input wire logic aleOut,         // Address latch enable
  input wire logic [23:0] addrOut, // Address lines
  input wire logic [15:0] dataOut, // Demux write data
  input wire logic [15:0] adOut,   // Shared lines from the device
  input wire logic muxMode,        // 1: shared address/data lines
  input wire logic [4:0] waitCyc,  // Strobe cycles before ready
  input wire logic polHigh,        // 1: high means ready
  input wire logic asyncMode,      // 1: ready moves off the clock
  output logic readyPin,           // Ready pin
  output logic [15:0] dataIn,      // Demux read data
  output logic [15:0] adIn         // Shared lines read data
);
  logic [15:0] mem [256];
  logic [7:0] muxAddr_r;
  logic [7:0] idx;
  logic [4:0] cnt_r = 5'h0;
  logic [15:0] last_r = 16'h0;
  logic drive;
  logic act;

  // =====================================================================
  // Addressing and read drive
  assign idx = muxMode ? muxAddr_r : addrOut[7:0];
  assign drive = !rdN && !(&csN);
  // Released lines show the inverse, so a stale value never looks valid
  assign dataIn = (drive && !muxMode) ? mem[idx] : ~last_r;
  assign adIn = (drive && muxMode) ? mem[idx] : ~last_r;

  // Address latch, write capture, strobe length count
  always @(posedge clk) begin
    if (aleOut) muxAddr_r <= adOut[7:0];
    if (!wrN) mem[idx] <= muxMode ? adOut : dataOut;
    if (drive) last_r <= mem[idx];
    cnt_r <= (rdN && wrN) ? 5'h0 : ((cnt_r == 5'h1f) ? cnt_r : cnt_r + 5'h1);
  end

  // =====================================================================
  // Ready: active until the strobe rises, so held well over one period
  assign act = !(rdN && wrN) && (cnt_r >= waitCyc);
  // Sync mode moves 2 ns after the clock, async mode 37 ns after it
  always @(act, polHigh, asyncMode) begin
    readyPin <= #(asyncMode ? 37 : 2) (act == polHigh);
  end
endmodule // ebcrdy_partner

// ---- verif/external_bus_cycle_ready_control_test.sv ----
// Self-checking bench for the bus cycle sequencer and its ready handshake
`timescale 1ns/1ps
module external_bus_cycle_ready_control_test;
  import ebcrdy_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic reqValid = 1'h0;
  logic reqWrite = 1'h0;
  logic [CS_W-1:0] reqCs = 2'h0;
  logic [ADDR_W-1:0] reqAddr = 24'h0;
  logic [DATA_W-1:0] reqWdata = 16'h0;
  logic [NUM_CS*TIMING_W-1:0] csTiming = 68'h0;
  logic muxMode = 1'h0;
  logic asyncMode = 1'h0;
  logic polHigh = 1'h0;
  logic [4:0] waitCyc = 5'h1f;
  logic readyPin, reqReady_r, done_r, dataOe_r, adOe_r, aleOut_r, rdN_r, wrN_r, busRefClkOut;
  logic [DATA_W-1:0] dataIn, adIn, rdata_r, dataOut_r, adOut_r, rd;
  logic [ADDR_W-1:0] addrOut_r;
  logic [NUM_CS-1:0] csN_r;
  int fails = 0;
  int totalChecks = 0;
  int cyc, n4, expCyc;
  int syncCnt [2];
  logic [2:0] tAb [3] = '{3'h1, 3'h2, 3'h5};
  logic [1:0] tC [3] = '{2'h0, 2'h3, 2'h1};
  logic tD [3] = '{1'h0, 1'h1, 1'h0};
  logic [5:0] tE [3] = '{6'h3, 6'h20, 6'h4};
  logic [1:0] tF [3] = '{2'h0, 2'h3, 2'h1};
  logic tMux [3] = '{1'h0, 1'h1, 1'h0};

  // Clock: 100 ns period
  always #50 ref_clk = ~ref_clk;

  ebcrdy_seq i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqCs(reqCs), .reqAddr(reqAddr), .reqWdata(reqWdata), .csTiming(csTiming),
    .readyPin(readyPin), .dataIn(dataIn), .adIn(adIn), .reqReady_r(reqReady_r),
    .done_r(done_r), .rdata_r(rdata_r), .addrOut_r(addrOut_r), .dataOut_r(dataOut_r),
    .dataOe_r(dataOe_r), .adOut_r(adOut_r), .adOe_r(adOe_r), .aleOut_r(aleOut_r),
    .rdN_r(rdN_r), .wrN_r(wrN_r), .csN_r(csN_r), .busRefClkOut(busRefClkOut));

  ebcrdy_partner i_mem (.clk(busRefClkOut), .csN(csN_r), .rdN(rdN_r), .wrN(wrN_r),
    .aleOut(aleOut_r), .addrOut(addrOut_r), .dataOut(dataOut_r), .adOut(adOut_r),
    .muxMode(muxMode), .waitCyc(waitCyc), .polHigh(polHigh), .asyncMode(asyncMode),
    .readyPin(readyPin), .dataIn(dataIn), .adIn(adIn));

  // =====================================================================
  // Verdict, comparison and bus tasks
  task automatic stop_test();
    if (fails == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Program one region and match the partner to it; mode is mux,async,pol,en
  task automatic cfg(input int n, input logic [2:0] ab, input logic [1:0] c, input logic d,
    input logic [5:0] e, input logic [1:0] f, input logic [3:0] mode);
    @(posedge ref_clk);
    csTiming[n*TIMING_W +: TIMING_W] <= {mode, f, 5'(e - 6'h1), d, c, ab};
    muxMode <= mode[3];
    asyncMode <= mode[2];
    polHigh <= mode[1];
  endtask

  // One access; request held until taken, cycles counted up to done
  task automatic access(input logic [1:0] cs, input logic wr, input logic [7:0] a,
    input logic [15:0] wd, input logic [4:0] w, output int n);
    int i;
    @(posedge ref_clk);
    reqValid <= 1'h1;
    reqWrite <= wr;
    reqCs <= cs;
    reqAddr <= {16'ha5c3, a};
    reqWdata <= wd;
    waitCyc <= w;
    @(negedge ref_clk);
    for (i = 0; i < 100 && reqReady_r !== 1'h1; i++) @(negedge ref_clk);
    @(posedge ref_clk);
    reqValid <= 1'h0;
    for (n = 1; n < 200; n++) begin
      @(negedge ref_clk);
      if (n == 2) chk(csN_r, 4'(~(4'h1 << cs)));
      if (n == 2) chk(addrOut_r, {16'ha5c3, a});
      if (done_r === 1'h1) break;
    end
    chk(done_r, 1'h1);
    rd = rdata_r;
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(negedge ref_clk);
    chk(reqReady_r, 1'h1);
    chk(csN_r, 4'hf);
    @(posedge ref_clk);
    #1 chk(busRefClkOut, 1'h1);
    // Fixed lengths, handshake disabled: boundary phase values per region
    for (int i = 0; i < 3; i++) begin
      cfg(i, tAb[i], tC[i], tD[i], tE[i], tF[i], {tMux[i], 3'h0});
      expCyc = tAb[i] + tC[i] + tD[i] + tE[i] + tF[i] + 1;
      access(2'(i), 1'h1, 8'(16 + i), 16'hc3a0 ^ 16'(i), 5'h1f, cyc);
      chk(cyc, expCyc);
      chk(i_mem.mem[16 + i], 16'hc3a0 ^ 16'(i));
      access(2'(i), 1'h0, 8'(16 + i), 16'h0, 5'h1f, cyc);
      chk(rd, 16'hc3a0 ^ 16'(i));
      chk(cyc, expCyc);
    end
    // Handshake in sync and async mode, both polarities
    for (int m = 0; m < 4; m++) begin
      cfg(3, 3'h1, 2'h0, 1'h0, 6'h1, 2'h0, {1'h0, m[1], m[0], 1'h1});
      access(2'h3, 1'h0, 8'h10, 16'h0, 5'h4, n4);
      chk(rd, 16'hc3a0);
      chk(n4 >= 6, 1'h1);
      access(2'h3, 1'h0, 8'h10, 16'h0, 5'ha, cyc);
      chk(cyc - n4, 6);
      if (!m[1]) syncCnt[m[0]] = n4;
      else chk(n4 > syncCnt[m[0]], 1'h1);
    end
    // Ready already active before the mandatory access cycles run out
    cfg(3, 3'h1, 2'h0, 1'h0, 6'h8, 2'h0, 4'h3);
    access(2'h3, 1'h0, 8'h11, 16'h0, 5'h0, cyc);
    chk(cyc >= 10, 1'h1);
    chk(rd, 16'hc3a1);
    stop_test();
  end

  // Watchdog: the whole run needs well under 2 ms
  initial begin
    #2000000;
    fails++;
    stop_test();
  end
endmodule // external_bus_cycle_ready_control_test
